/* File: design/ocr_recorder.sv */
// Purpose: event generation, counters and fault records for one stage instance
// Assumes: status and measurement inputs synchronous to clock_i
// Notes: one event per cycle leaves; simultaneous changes are emitted in bit order
`timescale 1ns/1ps
// How it works
// - event on each status bit edge
// - polarity select gates buffer writes
// - events carry millisecond time stamp
// - start trip block counters, clearable
// - twelve records per instance, readable by index
// - record written only on on-edges
// - record holds stamp, event, currents, time, group
// - status outputs forwarded for io and logic
module ocr_recorder
    import ocr_pkg::*;
#(
    parameter int CW = 16,
    parameter int IW = 16,
    parameter int TW = 24
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [NUM_STAT-1:0] status_i,
    input wire logic [1:0] event_sel_i,
    input wire logic counter_clear_i,
    input wire logic [IW-1:0] current_i,
    input wire logic [3:0] fault_type_i,
    input wire logic [TW-1:0] trip_remain_i,
    input wire logic [2:0] group_i,
    input wire logic [3:0] rec_index_i,
    output logic [NUM_STAT-1:0] status_o,
    output logic ev_valid_o,
    output logic [4:0] ev_code_o,
    output logic ev_on_o,
    output logic [31:0] ev_stamp_o,
    output logic [CW-1:0] start_count_o,
    output logic [CW-1:0] trip_count_o,
    output logic [CW-1:0] block_count_o,
    output logic [3:0] rec_count_o,
    output logic [31:0] rec_stamp_o,
    output logic [4:0] rec_event_o,
    output logic [3:0] rec_ftype_o,
    output logic [IW-1:0] rec_pre20_o,
    output logic [IW-1:0] rec_fault_o,
    output logic [IW-1:0] rec_pre200_o,
    output logic [TW-1:0] rec_remain_o,
    output logic [2:0] rec_group_o
);
    localparam logic [3:0] LAST_SLOT = 4'(NUM_REC - 1);
    logic [NUM_STAT-1:0] prev_reg;
    logic [NUM_STAT-1:0] pend_reg;
    logic [NUM_STAT-1:0] pend_on_reg;
    logic [31:0] stamp_pend_reg [NUM_STAT];
    logic [31:0] ms_reg;
    logic [$clog2(MS_CYCLES)-1:0] div_reg;
    logic tick;
    logic [NUM_STAT-1:0] edge_on;
    logic [NUM_STAT-1:0] edge_any;
    logic [IW-1:0] pre20;
    logic [IW-1:0] pre200;
    logic [3:0] wr_ptr_reg;
    logic [31:0] r_stamp [NUM_REC];
    logic [4:0] r_event [NUM_REC];
    logic [3:0] r_ftype [NUM_REC];
    logic [IW-1:0] r_pre20 [NUM_REC];
    logic [IW-1:0] r_fault [NUM_REC];
    logic [IW-1:0] r_pre200 [NUM_REC];
    logic [TW-1:0] r_remain [NUM_REC];
    logic [2:0] r_group [NUM_REC];
    logic [3:0] pick;
    logic pick_ok;
    logic [3:0] rec_pick;
    logic rec_ok;
    logic [4:0] rd_slot;

    function automatic logic [3:0] first_set(input logic [NUM_STAT-1:0] v);
        logic [3:0] r;
        r = 4'hF;
        for (int i = NUM_STAT - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    ocr_history #(
        .W(IW),
        .DEPTH(PRE_FAULT_MS)
    ) u_hist (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .tick_i(tick),
        .cur_i(current_i),
        .pre20_o(pre20),
        .pre200_o(pre200)
    );

    assign tick = (div_reg == ($clog2(MS_CYCLES))'(MS_CYCLES - 1));
    assign edge_any = status_i ^ prev_reg;
    assign edge_on = status_i & ~prev_reg;

    // millisecond time base for stamps
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            div_reg <= '0;
            ms_reg <= TS_RESET;
        end else if (tick) begin
            div_reg <= '0;
            ms_reg <= ms_reg + 32'h1;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            prev_reg <= '0;
            status_o <= '0;
        end else begin
            prev_reg <= status_i;
            status_o <= status_i;
        end
    end

    // polarity filter before queueing; unselected edges never reach the buffer
    always_comb begin
        pick = first_set(pend_reg);
        pick_ok = (pick != 4'hF);
    end

    // a pending edge of a bit is replaced if the bit has another selected edge before emission
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            pend_reg <= '0;
            pend_on_reg <= '0;
            for (int i = 0; i < NUM_STAT; i++) begin
                stamp_pend_reg[i] <= TS_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_STAT; i++) begin
                if (edge_any[i] && ((edge_on[i] && event_sel_i[0]) ||
                    (!edge_on[i] && event_sel_i[1]))) begin
                    pend_reg[i] <= 1'b1;
                    pend_on_reg[i] <= edge_on[i];
                    stamp_pend_reg[i] <= ms_reg;
                end else if (pick_ok && pick == 4'(i)) begin
                    pend_reg[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            ev_valid_o <= 1'b0;
            ev_code_o <= 5'h0;
            ev_on_o <= 1'b0;
            ev_stamp_o <= TS_RESET;
        end else begin
            ev_valid_o <= pick_ok;
            if (pick_ok) begin
                ev_code_o <= {pick, pend_on_reg[pick]};
                ev_on_o <= pend_on_reg[pick];
                ev_stamp_o <= stamp_pend_reg[pick];
            end
        end
    end

    // a clear coincident with an event loads one so the event is kept
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            start_count_o <= CNT_RESET;
            trip_count_o <= CNT_RESET;
            block_count_o <= CNT_RESET;
        end else begin
            if (edge_on[ST_START]) begin
                start_count_o <= counter_clear_i ? CW'(1) : start_count_o + 1'b1;
            end else if (counter_clear_i) begin
                start_count_o <= CNT_RESET;
            end
            if (edge_on[ST_TRIP]) begin
                trip_count_o <= counter_clear_i ? CW'(1) : trip_count_o + 1'b1;
            end else if (counter_clear_i) begin
                trip_count_o <= CNT_RESET;
            end
            if (edge_on[ST_BLOCK]) begin
                block_count_o <= counter_clear_i ? CW'(1) : block_count_o + 1'b1;
            end else if (counter_clear_i) begin
                block_count_o <= CNT_RESET;
            end
        end
    end

    // one record per cycle; start takes priority over trip and block
    always_comb begin
        rec_pick = first_set(NUM_STAT'(edge_on[2:0]));
        rec_ok = (edge_on[2:0] != 3'h0);
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            wr_ptr_reg <= 4'h0;
            rec_count_o <= 4'h0;
            for (int i = 0; i < NUM_REC; i++) begin
                r_stamp[i] <= TS_RESET;
                r_event[i] <= 5'h0;
                r_ftype[i] <= 4'h0;
                r_pre20[i] <= '0;
                r_fault[i] <= '0;
                r_pre200[i] <= '0;
                r_remain[i] <= '0;
                r_group[i] <= 3'h0;
            end
        end else if (rec_ok) begin
            r_stamp[wr_ptr_reg] <= ms_reg;
            r_event[wr_ptr_reg] <= {rec_pick, 1'b1};
            r_ftype[wr_ptr_reg] <= fault_type_i;
            r_pre20[wr_ptr_reg] <= pre20;
            r_fault[wr_ptr_reg] <= current_i;
            r_pre200[wr_ptr_reg] <= pre200;
            r_remain[wr_ptr_reg] <= trip_remain_i;
            r_group[wr_ptr_reg] <= group_i;
            wr_ptr_reg <= (wr_ptr_reg == LAST_SLOT) ? 4'h0 : wr_ptr_reg + 4'h1;
            if (rec_count_o != 4'(NUM_REC)) begin
                rec_count_o <= rec_count_o + 4'h1;
            end
        end
    end

    // index 0 is the newest record
    always_comb begin
        rd_slot = {1'b0, wr_ptr_reg} + 5'(NUM_REC) - 5'h1 - {1'b0, rec_index_i};
        if (rd_slot >= 5'(NUM_REC)) begin
            rd_slot = rd_slot - 5'(NUM_REC);
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rec_stamp_o <= TS_RESET;
            rec_event_o <= 5'h0;
            rec_ftype_o <= 4'h0;
            rec_pre20_o <= '0;
            rec_fault_o <= '0;
            rec_pre200_o <= '0;
            rec_remain_o <= '0;
            rec_group_o <= 3'h0;
        end else if (rec_index_i < 4'(NUM_REC)) begin
            rec_stamp_o <= r_stamp[rd_slot[3:0]];
            rec_event_o <= r_event[rd_slot[3:0]];
            rec_ftype_o <= r_ftype[rd_slot[3:0]];
            rec_pre20_o <= r_pre20[rd_slot[3:0]];
            rec_fault_o <= r_fault[rd_slot[3:0]];
            rec_pre200_o <= r_pre200[rd_slot[3:0]];
            rec_remain_o <= r_remain[rd_slot[3:0]];
            rec_group_o <= r_group[rd_slot[3:0]];
        end
    end

    AST_START_COUNT: assert property (@(posedge clock_i) disable iff (reset_i)
        (edge_on[ST_START] && !counter_clear_i) |=> start_count_o == $past(start_count_o) + 1'b1)
        else $error("start counter missed an event");
    AST_CLEAR: assert property (@(posedge clock_i) disable iff (reset_i)
        (counter_clear_i && !edge_on[ST_TRIP]) |=> trip_count_o == CNT_RESET)
        else $error("trip counter not cleared");
    // checked at queue entry: emission may lag a later select change
    AST_ON_SEL: assert property (@(posedge clock_i) disable iff (reset_i)
        !event_sel_i[0] |=> (pend_reg & pend_on_reg & ~$past(pend_reg)) == '0)
        else $error("unselected on event queued");
    AST_OFF_SEL: assert property (@(posedge clock_i) disable iff (reset_i)
        !event_sel_i[1] |=> (pend_reg & ~pend_on_reg & ~$past(pend_reg)) == '0)
        else $error("unselected off event queued");
    AST_EVENT_OUT: assert property (@(posedge clock_i) disable iff (reset_i)
        (edge_any[ST_TRIP] && event_sel_i == SEL_BOTH) |-> ##[1:10] ev_valid_o)
        else $error("trip change produced no event");
    AST_STAMP: assert property (@(posedge clock_i) disable iff (reset_i)
        ev_valid_o |-> ev_stamp_o <= ms_reg)
        else $error("event stamp is in the future");
    AST_REC_ON_ONLY: assert property (@(posedge clock_i) disable iff (reset_i)
        !rec_ok |=> wr_ptr_reg == $past(wr_ptr_reg))
        else $error("record written without on edge");
    AST_REC_WRAP: assert property (@(posedge clock_i) disable iff (reset_i)
        (rec_ok && wr_ptr_reg == LAST_SLOT) |=> wr_ptr_reg == 4'h0)
        else $error("record pointer did not wrap");
    AST_REC_COUNT: assert property (@(posedge clock_i) disable iff (reset_i)
        rec_count_o <= 4'(NUM_REC))
        else $error("record count above capacity");
    AST_FWD: assert property (@(posedge clock_i) disable iff (reset_i)
        ##1 status_o == $past(status_i))
        else $error("status not forwarded");
    COV_ON: cover property (@(posedge clock_i) ev_valid_o && ev_on_o);
    COV_OFF: cover property (@(posedge clock_i) ev_valid_o && !ev_on_o);
    COV_WRAP: cover property (@(posedge clock_i) rec_ok && wr_ptr_reg == LAST_SLOT);
    COV_CLR: cover property (@(posedge clock_i) counter_clear_i && edge_on[ST_START]);
endmodule

/* File: design/ocr_pkg.sv */
// Purpose: shared constants and types for the overcurrent event recorder
// Assumes: one 20 MHz clock, synchronous active-high reset
// Notes: event codes index the per-instance status bits
package ocr_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int MS_TIME = 1;
    localparam int MS_CYCLES = CLK_HZ / 1000 * MS_TIME;
    localparam int PRE_TRIG_MS = 20;
    localparam int PRE_FAULT_MS = 200;
    localparam int NUM_REC = 12;
    localparam int NUM_STAT = 9;
    localparam logic [1:0] SEL_ON = 2'h1;
    localparam logic [1:0] SEL_OFF = 2'h2;
    localparam logic [1:0] SEL_BOTH = 2'h3;
    localparam logic [31:0] TS_RESET = 32'h0;
    localparam logic [15:0] CNT_RESET = 16'h0;
    // status bit order: start, trip, block, start a/b/c, trip a/b/c
    localparam int ST_START = 0;
    localparam int ST_TRIP = 1;
    localparam int ST_BLOCK = 2;
    typedef enum logic [2:0] {
        OCR_IDLE = 3'b001,
        OCR_SCAN = 3'b010,
        OCR_DONE = 3'b100
    } ocr_scan_t;
endpackage

/* File: design/ocr_history.sv */
// Purpose: pre-trigger and pre-fault current history taps
// Assumes: one sample per millisecond tick
// Notes: shift line of flip-flops, depth set by parameter
`timescale 1ns/1ps
module ocr_history
    import ocr_pkg::*;
#(
    parameter int W = 16,
    parameter int DEPTH = PRE_FAULT_MS
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic tick_i,
    input wire logic [W-1:0] cur_i,
    output logic [W-1:0] pre20_o,
    output logic [W-1:0] pre200_o
);
    logic [W-1:0] line_reg [DEPTH];
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                line_reg[i] <= '0;
            end
        end else if (tick_i) begin
            line_reg[0] <= cur_i;
            for (int i = 1; i < DEPTH; i++) begin
                line_reg[i] <= line_reg[i-1];
            end
        end
    end
    assign pre20_o = line_reg[PRE_TRIG_MS-1];
    assign pre200_o = line_reg[DEPTH-1];
endmodule

/* File: test/ocr_stage_model.sv */
// Purpose: behavioural overcurrent stage feeding status and measurements
// Assumes: outputs change only at the falling clock edge
// Notes: the bench steers it through set_bit, one status bit per call
`timescale 1ns/1ps
module ocr_stage_model
    import ocr_pkg::*;
(
    input wire logic clock_i,
    output logic [NUM_STAT-1:0] status_o,
    output logic [15:0] current_o,
    output logic [3:0] fault_type_o,
    output logic [23:0] trip_remain_o,
    output logic [2:0] group_o
);
    initial begin
        status_o = '0;
        current_o = 16'h0000;
        fault_type_o = 4'h0;
        trip_remain_o = 24'h000000;
        group_o = 3'h0;
    end

    // measurements follow cur so each record is traceable
    task automatic set_bit(input int idx, input logic val, input logic [15:0] cur);
        @(negedge clock_i);
        status_o[idx] = val;
        current_o = cur;
        fault_type_o = cur[3:0];
        trip_remain_o = {8'h00, cur};
        group_o = cur[2:0];
    endtask
endmodule

/* File: test/ocr_recorder_test.sv */
// Purpose: self-checking bench for the overcurrent event recorder
// Assumes: inputs driven at the falling edge, outputs sampled there
// Notes: history taps need 20 ms and more, too long for this run
`timescale 1ns/1ps
module ocr_recorder_test
    import ocr_pkg::*;
;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic [1:0] event_sel_i = SEL_BOTH;
    logic counter_clear_i = 1'b0;
    logic [3:0] rec_index_i = 4'h0;
    logic [NUM_STAT-1:0] status_i, status_o;
    logic [15:0] current_i, rec_pre20_o, rec_fault_o, rec_pre200_o;
    logic [15:0] start_count_o, trip_count_o, block_count_o;
    logic [3:0] fault_type_i, rec_count_o, rec_ftype_o;
    logic [23:0] trip_remain_i, rec_remain_o;
    logic [2:0] group_i, rec_group_o;
    logic ev_valid_o, ev_on_o;
    logic [4:0] ev_code_o, rec_event_o;
    logic [31:0] ev_stamp_o, rec_stamp_o;
    int n_mismatch = 0;
    int n_tests = 0;

    always #25 clock_i = ~clock_i;

    ocr_stage_model u_ocr_stage_model (.clock_i(clock_i), .status_o(status_i),
        .current_o(current_i), .fault_type_o(fault_type_i),
        .trip_remain_o(trip_remain_i), .group_o(group_i));

    ocr_recorder u_ocr_recorder (.clock_i(clock_i), .reset_i(reset_i), .status_i(status_i),
        .event_sel_i(event_sel_i), .counter_clear_i(counter_clear_i),
        .current_i(current_i), .fault_type_i(fault_type_i), .trip_remain_i(trip_remain_i),
        .group_i(group_i), .rec_index_i(rec_index_i), .status_o(status_o),
        .ev_valid_o(ev_valid_o), .ev_code_o(ev_code_o), .ev_on_o(ev_on_o),
        .ev_stamp_o(ev_stamp_o), .start_count_o(start_count_o),
        .trip_count_o(trip_count_o), .block_count_o(block_count_o),
        .rec_count_o(rec_count_o), .rec_stamp_o(rec_stamp_o), .rec_event_o(rec_event_o),
        .rec_ftype_o(rec_ftype_o), .rec_pre20_o(rec_pre20_o), .rec_fault_o(rec_fault_o),
        .rec_pre200_o(rec_pre200_o), .rec_remain_o(rec_remain_o),
        .rec_group_o(rec_group_o));

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // bounded wait: a lost event ends the run
    task automatic toggle_expect(input int idx, input logic val, input logic [15:0] cur);
        int k;
        u_ocr_stage_model.set_bit(idx, val, cur);
        for (k = 0; k < 12 && ev_valid_o !== 1'b1; k++) begin
            @(negedge clock_i);
        end
        if (ev_valid_o !== 1'b1) begin
            n_mismatch++;
            $display("Error ev_valid_o expected 1 seen none");
            results();
        end
        check("ev_code_o", {idx[3:0], val}, ev_code_o);
        check("ev_on_o", val, ev_on_o);
    endtask

    task automatic toggle_silent(input int idx, input logic val);
        int seen;
        seen = 0;
        u_ocr_stage_model.set_bit(idx, val, 16'h0000);
        repeat (12) begin
            @(negedge clock_i);
            seen += (ev_valid_o === 1'b1) ? 1 : 0;
        end
        check("event count", 0, seen);
    endtask

    task automatic read_rec(input logic [3:0] idx);
        rec_index_i = idx;
        repeat (2) @(negedge clock_i);
    endtask

    task automatic t_stamp_record();
        repeat (25000) @(negedge clock_i);
        toggle_expect(ST_TRIP, 1'b1, 16'h0123);
        check("ev_stamp_o", 32'h1, ev_stamp_o);
        @(negedge clock_i);
        check("trip_count_o", 16'h1, trip_count_o);
        check("rec_count_o", 4'h1, rec_count_o);
        read_rec(4'h0);
        check("rec_event_o", 5'h03, rec_event_o);
        check("rec_stamp_o", 32'h1, rec_stamp_o);
        check("rec_fault_o", 16'h0123, rec_fault_o);
        check("rec_ftype_o", 4'h3, rec_ftype_o);
        check("rec_remain_o", 24'h000123, rec_remain_o);
        check("rec_group_o", 3'h3, rec_group_o);
        // only one ms of zero current lies behind the fault
        check("rec_pre20_o", 16'h0, rec_pre20_o);
        check("rec_pre200_o", 16'h0, rec_pre200_o);
        toggle_expect(ST_TRIP, 1'b0, 16'h0000);
        check("rec_count_o", 4'h1, rec_count_o);
    endtask

    task automatic t_polarity();
        event_sel_i = SEL_ON;
        toggle_expect(ST_BLOCK, 1'b1, 16'h0000);
        toggle_silent(ST_BLOCK, 1'b0);
        event_sel_i = SEL_OFF;
        toggle_silent(ST_BLOCK, 1'b1);
        toggle_expect(ST_BLOCK, 1'b0, 16'h0000);
        event_sel_i = 2'h0;
        toggle_silent(ST_BLOCK, 1'b1);
        toggle_silent(ST_BLOCK, 1'b0);
        event_sel_i = SEL_BOTH;
        // selection filters the buffer only, not counters or records
        check("block_count_o", 16'h3, block_count_o);
        check("rec_count_o", 4'h4, rec_count_o);
    endtask

    task automatic t_all_codes();
        for (int i = 0; i < NUM_STAT; i++) begin
            toggle_expect(i, 1'b1, 16'h0000);
            check("status_o", 9'h001 << i, status_o);
            toggle_expect(i, 1'b0, 16'h0000);
        end
    endtask

    task automatic t_overwrite();
        counter_clear_i = 1'b1;
        @(negedge clock_i);
        counter_clear_i = 1'b0;
        @(negedge clock_i);
        check("start_count_o", 16'h0, start_count_o);
        for (int k = 1; k <= 13; k++) begin
            toggle_expect(ST_START, 1'b1, k[15:0]);
            toggle_expect(ST_START, 1'b0, 16'h0000);
        end
        check("start_count_o", 16'hD, start_count_o);
        check("rec_count_o", 4'hC, rec_count_o);
        read_rec(4'h0);
        check("newest fault", 16'hD, rec_fault_o);
        read_rec(4'hB);
        check("oldest fault", 16'h2, rec_fault_o);
        counter_clear_i = 1'b1;
        @(negedge clock_i);
        counter_clear_i = 1'b0;
        @(negedge clock_i);
        check("start_count_o", 16'h0, start_count_o);
        check("trip_count_o", 16'h0, trip_count_o);
        check("block_count_o", 16'h0, block_count_o);
    endtask

    initial begin
        repeat (10) @(negedge clock_i);
        reset_i = 1'b0;
        t_stamp_record();
        t_polarity();
        t_all_codes();
        t_overwrite();
        results();
    end
endmodule
